// ==== core/acs_map.vh ====
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// result and filter widths
`define ACS_CODE_W        12
`define ACS_CNT_W         11
`define ACS_GAIN_W        21
`define ACS_GAIN_SHIFT    16
`define ACS_CODE_MAX      12'h7FF
`define ACS_CODE_MIN      12'h800

// data_rate_select encodings, slowest to fastest
`define ACS_DRS_128       3'h0
`define ACS_DRS_250       3'h1
`define ACS_DRS_490       3'h2
`define ACS_DRS_920       3'h3
`define ACS_DRS_1600      3'h4
`define ACS_DRS_2400      3'h5
`define ACS_DRS_3300      3'h6
`define ACS_DRS_RESET     3'h0

// modulator rate and output rates in samples per second
`define ACS_FMOD_HZ       250000
`define ACS_SPS_128       128
`define ACS_SPS_250       250
`define ACS_SPS_490       490
`define ACS_SPS_920       920
`define ACS_SPS_1600      1600
`define ACS_SPS_2400      2400
`define ACS_SPS_3300      3300

// modulator bits per conversion, one settling cycle, rounded down
`define ACS_LEN_128       11'h7A1
`define ACS_LEN_250       11'h3E8
`define ACS_LEN_490       11'h1FE
`define ACS_LEN_920       11'h10F
`define ACS_LEN_1600      11'h09C
`define ACS_LEN_2400      11'h068
`define ACS_LEN_3300      11'h04B
// filter gain so a full-scale ones count maps onto full-scale code
`define ACS_GN_128        21'h010C73
`define ACS_GN_250        21'h020C49
`define ACS_GN_490        21'h040404
`define ACS_GN_920        21'h078EA4
`define ACS_GN_1600       21'h0D20D2
`define ACS_GN_2400       21'h13B13B
`define ACS_GN_3300       21'h1B4E81

// reset value of the mode selection: single-shot
`define ACS_MODE_RESET    1'b0

`endif

// ==== core/acs_adc_conversion_sequencer.v ====
// What this block does
// - each single-shot request runs exactly one conversion
// - single-shot result goes into the result register, then power down
// - continuous mode restarts the next conversion at once, unprompted
// - continuous results arrive at the programmed data rate
// - result output holds the newest completed conversion until a general call clears it
// - filter turns modulator one-bit stream into a proportional 12-bit code
// - one mode bit chooses continuous or single-shot conversion
// - after power-up: defaults loaded, powered down, no conversions
// - general-call reset does the same as power-up
// - conversion lasts one settling cycle, 1/rate, seven rates
`timescale 1ns/100ps
`include "acs_map.vh"

module acs_adc_conversion_sequencer (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   mod_clk,
  input  wire                   mod_bit,
  input  wire                   mode_continuous,
  input  wire [2:0]             data_rate_select,
  input  wire                   start_req,
  input  wire                   gen_call_reset,
  output reg  [`ACS_CODE_W-1:0] conv_result_r,
  output reg                    conv_done_r,
  output reg                    busy_r,
  output wire                   power_down
);

  localparam ST_DOWN = 1'b0;
  localparam ST_CONV = 1'b1;

  // three-stage synchronisers, one per pin: modulator clock and bit
  localparam PIN_N   = 2;
  localparam PIN_CLK = 0;
  localparam PIN_BIT = 1;

  wire [PIN_N-1:0] pin_raw = {mod_bit, mod_clk};
  wire [PIN_N-1:0] pin_agree;
  wire [PIN_N-1:0] pin_stage;
  wire [PIN_N-1:0] pin_lvl;
  wire             mclk_rise;
  wire             mbit_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_sync
      reg [2:0] sync_r;
      reg       lvl_r;
      // level resets to the idle low of the pin, so no false edge
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_r <= 3'h0;
          lvl_r  <= 1'b0;
        end else begin
          sync_r <= {sync_r[1:0], pin_raw[gi]};
          // a level change counts only once stages two and three agree
          if (sync_r[1] == sync_r[2])
            lvl_r <= sync_r[2];
        end
      end
      assign pin_agree[gi] = (sync_r[1] == sync_r[2]);
      assign pin_stage[gi] = sync_r[2];
      assign pin_lvl[gi]   = lvl_r;
    end
  endgenerate

  assign mclk_rise = pin_agree[PIN_CLK] && pin_stage[PIN_CLK] &&
                     !pin_lvl[PIN_CLK];
  assign mbit_lvl  = pin_lvl[PIN_BIT];

  // per-rate sample count and gain, taken at conversion start
  reg [`ACS_CNT_W-1:0]  rate_len;
  reg [`ACS_GAIN_W-1:0] rate_gain;

  always @* begin
    case (data_rate_select)
      `ACS_DRS_250: begin
        rate_len  = `ACS_LEN_250;
        rate_gain = `ACS_GN_250;
      end
      `ACS_DRS_490: begin
        rate_len  = `ACS_LEN_490;
        rate_gain = `ACS_GN_490;
      end
      `ACS_DRS_920: begin
        rate_len  = `ACS_LEN_920;
        rate_gain = `ACS_GN_920;
      end
      `ACS_DRS_1600: begin
        rate_len  = `ACS_LEN_1600;
        rate_gain = `ACS_GN_1600;
      end
      `ACS_DRS_2400: begin
        rate_len  = `ACS_LEN_2400;
        rate_gain = `ACS_GN_2400;
      end
      `ACS_DRS_3300, 3'h7: begin
        rate_len  = `ACS_LEN_3300;
        rate_gain = `ACS_GN_3300;
      end
      default: begin
        rate_len  = `ACS_LEN_128;
        rate_gain = `ACS_GN_128;
      end
    endcase
  end

  reg                   state_r;
  reg [`ACS_CNT_W-1:0]  len_r;
  reg [`ACS_GAIN_W-1:0] gain_r;
  reg [`ACS_CNT_W-1:0]  smp_cnt_r;
  reg [`ACS_CNT_W-1:0]  ones_r;

  // filter: ones density mapped to signed code, clamped to 12 bits
  wire [`ACS_CNT_W-1:0]   ones_fin = ones_r + {{(`ACS_CNT_W-1){1'b0}},
                                               mbit_lvl};
  wire signed [12:0]      dens = $signed({1'b0, ones_fin, 1'b0}) -
                                 $signed({2'b00, len_r});
  wire signed [34:0]      prod = dens * $signed({1'b0, gain_r});
  wire signed [18:0]      scaled = prod[34:`ACS_GAIN_SHIFT];
  reg  [`ACS_CODE_W-1:0]  code;

  always @* begin
    if (scaled > $signed(19'sh007FF))
      code = `ACS_CODE_MAX;
    else if (scaled < -$signed(19'sh00800))
      code = `ACS_CODE_MIN;
    else
      code = scaled[`ACS_CODE_W-1:0];
  end

  wire last_smp = mclk_rise && (smp_cnt_r == len_r - 1'b1);
  // a start in power-down: a request, or continuous mode selected
  wire go = start_req || mode_continuous;

  assign power_down = (state_r == ST_DOWN);

  reg                   state_nxt;
  reg [`ACS_CNT_W-1:0]  len_nxt;
  reg [`ACS_GAIN_W-1:0] gain_nxt;
  reg [`ACS_CNT_W-1:0]  smp_cnt_nxt;
  reg [`ACS_CNT_W-1:0]  ones_nxt;
  reg [`ACS_CODE_W-1:0] result_nxt;
  reg                   done_nxt;
  reg                   busy_nxt;

  // next-state logic; general call outranks everything else
  always @* begin
    state_nxt   = state_r;
    len_nxt     = len_r;
    gain_nxt    = gain_r;
    smp_cnt_nxt = smp_cnt_r;
    ones_nxt    = ones_r;
    result_nxt  = conv_result_r;
    done_nxt    = 1'b0;
    busy_nxt    = busy_r;
    if (gen_call_reset) begin
      // general call behaves as power-up; the old result is cleared too
      state_nxt   = ST_DOWN;
      smp_cnt_nxt = {`ACS_CNT_W{1'b0}};
      ones_nxt    = {`ACS_CNT_W{1'b0}};
      result_nxt  = {`ACS_CODE_W{1'b0}};
      busy_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_DOWN: begin
          if (go) begin
            state_nxt   = ST_CONV;
            busy_nxt    = 1'b1;
            len_nxt     = rate_len;
            gain_nxt    = rate_gain;
            smp_cnt_nxt = {`ACS_CNT_W{1'b0}};
            ones_nxt    = {`ACS_CNT_W{1'b0}};
          end
        end
        default: begin
          // requests while converting are ignored: one per conversion
          if (mclk_rise) begin
            smp_cnt_nxt = smp_cnt_r + 1'b1;
            ones_nxt    = ones_fin;
          end
          if (last_smp) begin
            // whole word replaced in one edge, reads never mix results
            result_nxt  = code;
            done_nxt    = 1'b1;
            smp_cnt_nxt = {`ACS_CNT_W{1'b0}};
            ones_nxt    = {`ACS_CNT_W{1'b0}};
            if (mode_continuous) begin
              len_nxt  = rate_len;
              gain_nxt = rate_gain;
            end else begin
              state_nxt = ST_DOWN;
              busy_nxt  = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // a rate change mid-conversion waits for the next latch point
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= ST_DOWN;
      len_r         <= {`ACS_CNT_W{1'b0}};
      gain_r        <= {`ACS_GAIN_W{1'b0}};
      smp_cnt_r     <= {`ACS_CNT_W{1'b0}};
      ones_r        <= {`ACS_CNT_W{1'b0}};
      conv_result_r <= {`ACS_CODE_W{1'b0}};
      conv_done_r   <= 1'b0;
      busy_r        <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      len_r         <= len_nxt;
      gain_r        <= gain_nxt;
      smp_cnt_r     <= smp_cnt_nxt;
      ones_r        <= ones_nxt;
      conv_result_r <= result_nxt;
      conv_done_r   <= done_nxt;
      busy_r        <= busy_nxt;
    end
  end

endmodule // acs_adc_conversion_sequencer

// ==== verification/acs_seq_asserts.sv ====
`timescale 1ns/100ps
module acs_seq_asserts (
  input logic        clk,
  input logic        rst_n,
  input logic        mod_clk,
  input logic        mod_bit,
  input logic        mode_continuous,
  input logic [2:0]  data_rate_select,
  input logic        start_req,
  input logic        gen_call_reset,
  input logic [11:0] conv_result_r,
  input logic        conv_done_r,
  input logic        busy_r,
  input logic        power_down
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    power_down && start_req && !gen_call_reset;
  endsequence
  sequence s_run;
    busy_r[*8];
  endsequence
  a_req_busy: assert property (s_req |=> s_run)
    else $error("request not taken");
  a_done_pulse: assert property (conv_done_r |=> !conv_done_r)
    else $error("done longer than one cycle");
  a_single_sleep: assert property (conv_done_r &&
    $past(!mode_continuous) |-> power_down && !busy_r)
    else $error("no power down after single shot");
  a_cont_rerun: assert property (conv_done_r &&
    $past(mode_continuous && !gen_call_reset) |-> busy_r && !power_down)
    else $error("continuous did not restart");
  a_result_hold: assert property ($changed(conv_result_r) |->
    conv_done_r || $past(gen_call_reset))
    else $error("result changed without completion");
  a_gcr_clear: assert property (gen_call_reset |=> power_down &&
    !busy_r && !conv_done_r && conv_result_r == 12'h000)
    else $error("general call did not reset");
  a_pd_idle: assert property (power_down |-> !busy_r)
    else $error("busy in power down");
  a_done_cause: assert property (conv_done_r |-> $past(busy_r))
    else $error("done without conversion");
  a_cont_start: assert property (power_down && mode_continuous &&
    !gen_call_reset |=> busy_r && !power_down)
    else $error("continuous mode did not start");
  a_done_edge: assert property (conv_done_r |->
    $past(mod_clk, 3) && $past(mod_clk, 4))
    else $error("done without a modulator edge");
endmodule // acs_seq_asserts

bind acs_adc_conversion_sequencer acs_seq_asserts u_acs_seq_asserts (
  .clk(clk), .rst_n(rst_n), .mod_clk(mod_clk), .mod_bit(mod_bit),
  .mode_continuous(mode_continuous), .data_rate_select(data_rate_select),
  .start_req(start_req), .gen_call_reset(gen_call_reset),
  .conv_result_r(conv_result_r), .conv_done_r(conv_done_r),
  .busy_r(busy_r), .power_down(power_down));

// ==== verification/acs_mod_src.sv ====
`timescale 1ns/100ps
module acs_mod_src (
  output logic mod_clk,
  output logic mod_bit,
  input  logic run,
  input  logic ones
);
  initial mod_clk = 1'b0;
  initial mod_bit = 1'b0;
  // clock stands still while the converter sleeps
  always #80 mod_clk = run ? ~mod_clk : 1'b0;
  // bit moves on the falling edge, stable at the sampling edge
  always @(negedge mod_clk or ones) if (!mod_clk) mod_bit <= ones;
endmodule // acs_mod_src

// ==== verification/tb_acs_adc_conversion_sequencer.sv ====
`timescale 1ns/100ps
module tb_acs_adc_conversion_sequencer;
  logic clk = 0, rst_n = 0, mc = 0, sr = 0, gc = 0, ones = 0;
  logic [2:0] drs = 3'h6;
  wire mod_clk, mod_bit, done, busy, pd;
  wire [11:0] res;
  int err_total = 0, checks = 0, n;
  always #5 clk = ~clk;
  acs_mod_src u_acs_mod_src (.mod_clk(mod_clk), .mod_bit(mod_bit),
    .run(!pd), .ones(ones));
  acs_adc_conversion_sequencer u_acs_adc_conversion_sequencer (
    .clk(clk), .rst_n(rst_n), .mod_clk(mod_clk), .mod_bit(mod_bit),
    .mode_continuous(mc), .data_rate_select(drs), .start_req(sr),
    .gen_call_reset(gc), .conv_result_r(res), .conv_done_r(done),
    .busy_r(busy), .power_down(pd));
  task chk(string nm, logic [11:0] e, logic [11:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task wd(int lim);
    n = 0;
    do begin @(negedge clk); n++; end while (done !== 1'b1 && n < lim);
  endtask
  task t_single(logic o, logic [11:0] e);
    ones = o; sr = 1;
    @(negedge clk) sr = 0;
    @(negedge clk) chk("busy", 1, busy);
    wd(3000);
    chk("code", e, res);
    chk("sleep", 1, pd);
    wd(2000);
    chk("extra", 2000, n);
    $display("single shot test done");
  endtask
  task t_cont(logic [2:0] r, int cyc);
    mc = 1; drs = r;
    wd(3000); wd(3000);
    wd(3000);
    chk("period", 1, n > cyc - 24 && n < cyc + 24);
    chk("busy", 1, busy);
    chk("code", 12'h800, res);
    $display("continuous test done");
  endtask
  task t_rate(logic [2:0] r, int cyc);
    drs = r; sr = 1;
    @(negedge clk) sr = 0;
    wd(40000);
    chk("rate", 1, n > cyc - 24 && n < cyc + 24);
    $display("rate test done");
  endtask
  task t_gcr();
    repeat (300) @(negedge clk);
    gc = 1; mc = 0;
    @(negedge clk) gc = 0;
    chk("pd", 1, pd);
    chk("res", 0, res);
    $display("general call test done");
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #950000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    chk("pd", 1, pd);
    chk("res", 0, res);
    t_single(1, 12'h7FF);
    t_single(0, 12'h800);
    t_cont(3'h6, 1200);
    t_cont(3'h5, 1664);
    t_gcr();
    t_rate(3'h4, 2496);
    t_rate(3'h3, 4336);
    t_rate(3'h2, 8160);
    t_rate(3'h1, 16000);
    t_rate(3'h0, 31248);
    t_rate(3'h7, 1200);
    wrap_up();
  end
endmodule // tb_acs_adc_conversion_sequencer
